// ===== rtl/srw_core.sv
// Readout window and frame timing generator with its register file
`timescale 1ns/1ps
// Summary of operation
// - Readout starts at programmed first row
// - Each row starts at programmed first column
// - Read programmed number of image rows
// - Read programmed number of image columns
// - Context B inserts its blank columns first
// - Context A inserts its blank columns first
// - Context B adds its blank rows per frame
// - Context A adds its blank rows per frame
// - Integration time may stretch vertical blanking
// - Integration time counted in rows
// - Invert bit selects pixel clock launch edge
// - Frame-synced values apply at next frame start unless sync_changes holds them
// - Frame start is first dark row read
// - Bad frames hidden unless shown on request
module srw_core (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [srw_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [srw_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [srw_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [1:0] context_select,
   input wire logic sync_changes,
   input wire logic show_bad_frames,
   output logic pixel_out_clock,
   output logic frame_valid,
   output logic line_valid,
   output logic [10:0] row_addr,
   output logic [10:0] col_addr,
   output logic frame_start,
   output logic bad_frame
);
   import srw_pkg::*;

   logic rst_m, rst_n;
   logic [SYNC_W-1:0] pins_s;
   logic [1:0] ctx;
   logic hold_chg, show_bad, pix_tick;
   logic [15:0] pend [1:NREG-1];
   logic [15:0] act [1:NREG-1];
   logic [15:0] next_pend [1:NREG-1];
   logic [15:0] next_act [1:NREG-1];
   logic [15:0] next_rdata;
   srw_state_t st, next_st;
   logic [16:0] row_cnt, next_row_cnt;
   logic [14:0] col_cnt, next_col_cnt;
   logic next_fv, next_lv, next_fs, next_bad;
   logic [10:0] next_row_addr, next_col_addr;
   logic [13:0] hb;
   logic [14:0] row_len;
   logic [16:0] vb, vb_min, vb_eff;
   logic row_end, new_frame, win_chg;

   // Field mask of a register offset, zero when unmapped
   function automatic logic [15:0] reg_mask(input logic [7:0] a);
      case (a)
         OFS_ROW, OFS_COL, OFS_NROWS, OFS_NCOLS: reg_mask = MASK_11;
         OFS_HB_B, OFS_HB_A: reg_mask = MASK_14;
         OFS_VB_B, OFS_VB_A: reg_mask = MASK_15;
         OFS_INTEG, OFS_PCLK: reg_mask = MASK_16;
         default: reg_mask = 16'h0000;
      endcase
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // External control levels
   srw_sync u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din({show_bad_frames, sync_changes, context_select}),
      .dout(pins_s)
   );
   assign ctx = pins_s[1:0];
   assign hold_chg = pins_s[2];
   assign show_bad = pins_s[3];

   // Pixel clock takes the written polarity directly
   srw_pclk u_pclk (
      .clk(ref_clk),
      .rst_n(rst_n),
      .invert(pend[OFS_PCLK][INV_BIT]),
      .pix_tick(pix_tick),
      .pclk(pixel_out_clock)
   );

   // Active timing fields by context
   always_comb begin
      hb = ctx[0] ? act[OFS_HB_B][13:0] : act[OFS_HB_A][13:0];
      vb = ctx[1] ? {2'b00, act[OFS_VB_B][14:0]} : {2'b00, act[OFS_VB_A][14:0]};
      row_len = 15'(hb) + 15'(act[OFS_NCOLS][10:0]);
      // Frame must span at least integration rows plus one
      vb_min = 17'(act[OFS_INTEG]) + 17'h0_0001 - DARK_ROWS - 17'(act[OFS_NROWS][10:0]);
      if (17'(act[OFS_INTEG]) + 17'h0_0001 <= DARK_ROWS + 17'(act[OFS_NROWS][10:0])) begin
         vb_min = 17'h0_0000;
      end
      vb_eff = (vb_min > vb) ? vb_min : vb;
      row_end = pix_tick && (col_cnt == row_len - 15'h0001);
      new_frame = row_end && (st == ST_VBLANK) && (row_cnt >= vb_eff - 17'h0_0001);
      win_chg = 1'b0;
      for (int i = 1; i <= 7; i++) begin
         if (i != 6 && pend[i] != act[i]) begin
            win_chg = 1'b1;
         end
      end
   end

   // Register writes, frame-start transfer and read data
   always_comb begin
      next_pend = pend;
      next_act = act;
      next_rdata = reg_rdata;
      if (reg_wr && reg_mask(reg_addr) != 16'h0000) begin
         next_pend[reg_addr[3:0]] = reg_wdata & reg_mask(reg_addr);
      end
      if (new_frame && !hold_chg) begin
         next_act = pend;
      end
      if (reg_rd) begin
         if (reg_addr == OFS_FIXED) begin
            next_rdata = FIXED_CODE;
         end else if (reg_mask(reg_addr) != 16'h0000) begin
            next_rdata = pend[reg_addr[3:0]];
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= '{RST_ROW, RST_COL, RST_NROWS, RST_NCOLS, RST_HB_B, RST_VB_B,
                   RST_HB_A, RST_VB_A, RST_INTEG, RST_PCLK};
         act <= '{RST_ROW, RST_COL, RST_NROWS, RST_NCOLS, RST_HB_B, RST_VB_B,
                  RST_HB_A, RST_VB_A, RST_INTEG, RST_PCLK};
         reg_rdata <= 16'h0000;
      end else begin
         pend <= next_pend;
         act <= next_act;
         reg_rdata <= next_rdata;
      end
   end

   // Row and column sequencing: dark rows, image rows, blank rows
   always_comb begin
      next_st = st;
      next_row_cnt = row_cnt;
      next_col_cnt = col_cnt;
      next_fs = 1'b0;
      next_bad = bad_frame;
      if (pix_tick) begin
         next_col_cnt = row_end ? 15'h0000 : col_cnt + 15'h0001;
      end
      if (row_end) begin
         next_row_cnt = row_cnt + 17'h0_0001;
         case (st)
            ST_DARK: begin
               if (row_cnt == DARK_ROWS - 17'h0_0001) begin
                  next_st = ST_IMAGE;
                  next_row_cnt = 17'h0_0000;
               end
            end
            ST_IMAGE: begin
               if (row_cnt == 17'(act[OFS_NROWS][10:0]) - 17'h0_0001) begin
                  next_st = ST_VBLANK;
                  next_row_cnt = 17'h0_0000;
               end
            end
            ST_VBLANK: begin
               if (new_frame) begin
                  next_st = ST_DARK;
                  next_row_cnt = 17'h0_0000;
                  next_fs = 1'b1;
                  next_bad = !hold_chg && win_chg;
               end
            end
            default: begin
               next_st = ST_VBLANK;
               next_row_cnt = 17'h0_0000;
            end
         endcase
      end
      next_fv = (next_st == ST_IMAGE) && !(next_bad && !show_bad);
      next_lv = next_fv && (next_col_cnt >= 15'(hb));
      next_row_addr = act[OFS_ROW][10:0] + next_row_cnt[10:0];
      next_col_addr = act[OFS_COL][10:0] + 11'(next_col_cnt - 15'(hb));
      if (!next_lv) begin
         next_col_addr = col_addr;
      end
      if (!next_fv) begin
         next_row_addr = row_addr;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_VBLANK;
         row_cnt <= 17'h0_0000;
         col_cnt <= 15'h0000;
         frame_valid <= 1'b0;
         line_valid <= 1'b0;
         row_addr <= 11'h000;
         col_addr <= 11'h000;
         frame_start <= 1'b0;
         bad_frame <= 1'b0;
      end else begin
         st <= next_st;
         row_cnt <= next_row_cnt;
         col_cnt <= next_col_cnt;
         frame_valid <= next_fv;
         line_valid <= next_lv;
         row_addr <= next_row_addr;
         col_addr <= next_col_addr;
         frame_start <= next_fs;
         bad_frame <= next_bad;
      end
   end

   // Helper counters for the checks below
   logic [31:0] fs_cyc, lv_cyc, gap_cyc;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_cyc <= 32'h0000_0000;
         lv_cyc <= 32'h0000_0000;
         gap_cyc <= 32'h0000_0000;
      end else begin
         fs_cyc <= frame_start ? 32'h0000_0001 : fs_cyc + 32'h0000_0001;
         lv_cyc <= line_valid ? lv_cyc + 32'h0000_0001 : 32'h0000_0000;
         // Gap counts only inside a frame, so the first line sees its own blank columns
         gap_cyc <= (line_valid || !frame_valid) ? 32'h0000_0000 : gap_cyc + 32'h0000_0001;
      end
   end

   // Frame, line and register checks, timing counted in master clocks
   a_first_row_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(frame_valid) |-> row_addr == act[OFS_ROW][10:0])
      else $error("first image row differs from row start");
   a_first_col_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_valid) |-> col_addr == act[OFS_COL][10:0])
      else $error("first column differs from column start");
   a_line_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(line_valid) && frame_valid |-> lv_cyc == 32'(act[OFS_NCOLS][10:0]) * PIX_DIV)
      else $error("line length differs from column count");
   a_hblank_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_valid) && $past(frame_valid) |-> gap_cyc == 32'(hb) * PIX_DIV)
      else $error("blank columns before line are wrong");
   a_dark_rows_lead: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(frame_valid) |-> fs_cyc == 32'(DARK_ROWS) * 32'(row_len) * PIX_DIV)
      else $error("frame valid not dark rows after frame start");
   a_apply_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start && !$past(hold_chg) |-> act[OFS_NROWS] == $past(pend[OFS_NROWS]))
      else $error("pending value not applied at frame start");
   a_hold_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(act[OFS_ROW]) |-> frame_start && !$past(hold_chg))
      else $error("active value changed outside frame start");
   a_bad_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bad_frame && !show_bad |-> !frame_valid && !line_valid)
      else $error("bad frame shown while masked");
   a_fixed_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFS_FIXED |=> reg_rdata == FIXED_CODE)
      else $error("fixed word read wrong");
   a_vblank_min: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start |-> $past(row_cnt) + 17'h0_0001 >= $past(vb))
      else $error("vertical blanking shorter than programmed");
   a_line_in_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
      line_valid |-> frame_valid)
      else $error("line valid outside frame valid");
   a_frame_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   a_pclk_launch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_valid) |-> pixel_out_clock == !$past(pend[OFS_PCLK][INV_BIT]))
      else $error("pixel clock phase wrong at line start");

   // Scenarios the bench is expected to reach
   c_bad_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start && bad_frame);
   c_ctx_b_line: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_valid) && ctx[0]);
   c_held_change: cover property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start && hold_chg && win_chg);
   c_ctx_b_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
      frame_start && ctx[1]);
   c_pclk_inverted: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_valid) && pend[OFS_PCLK][INV_BIT]);
endmodule

// ===== rtl/srw_pkg.sv
// Constants shared by the sensor readout window timing block
package srw_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NREG = 11;
   // Register offsets
   localparam logic [7:0] OFS_FIXED = 8'h00;
   localparam logic [7:0] OFS_ROW = 8'h01;
   localparam logic [7:0] OFS_COL = 8'h02;
   localparam logic [7:0] OFS_NROWS = 8'h03;
   localparam logic [7:0] OFS_NCOLS = 8'h04;
   localparam logic [7:0] OFS_HB_B = 8'h05;
   localparam logic [7:0] OFS_VB_B = 8'h06;
   localparam logic [7:0] OFS_HB_A = 8'h07;
   localparam logic [7:0] OFS_VB_A = 8'h08;
   localparam logic [7:0] OFS_INTEG = 8'h09;
   localparam logic [7:0] OFS_PCLK = 8'h0a;
   // Fixed word, value arbitrary
   localparam logic [15:0] FIXED_CODE = 16'h5a5a;
   // Values after reset
   localparam logic [15:0] RST_ROW = 16'h001c;
   localparam logic [15:0] RST_COL = 16'h003c;
   localparam logic [15:0] RST_NROWS = 16'h04b0;
   localparam logic [15:0] RST_NCOLS = 16'h0640;
   localparam logic [15:0] RST_HB_B = 16'h015c;
   localparam logic [15:0] RST_VB_B = 16'h0020;
   localparam logic [15:0] RST_HB_A = 16'h00ae;
   localparam logic [15:0] RST_VB_A = 16'h0010;
   localparam logic [15:0] RST_INTEG = 16'h04d0;
   localparam logic [15:0] RST_PCLK = 16'h0011;
   // Field masks
   localparam logic [15:0] MASK_11 = 16'h07ff;
   localparam logic [15:0] MASK_14 = 16'h3fff;
   localparam logic [15:0] MASK_15 = 16'h7fff;
   localparam logic [15:0] MASK_16 = 16'hffff;
   localparam int INV_BIT = 8;
   // Timing: pixel period in master clocks, dark rows before image
   localparam int PIX_DIV = 2;
   localparam logic [16:0] DARK_ROWS = 17'h0_0008;
   localparam int SYNC_W = 4;
   typedef enum logic [1:0] {ST_DARK, ST_IMAGE, ST_VBLANK} srw_state_t;
endpackage

// ===== rtl/srw_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module srw_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [srw_pkg::SYNC_W-1:0] din,
   output logic [srw_pkg::SYNC_W-1:0] dout
);
   import srw_pkg::*;
   logic [SYNC_W-1:0] s1, s2, s3;
   logic [SYNC_W-1:0] next_dout;

   // Output follows only once the second and third stages agree
   always_comb begin
      next_dout = dout;
      for (int i = 0; i < SYNC_W; i++) begin
         if (s2[i] == s3[i]) begin
            next_dout[i] = s3[i];
         end
      end
   end

   // Stage registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         dout <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= next_dout;
      end
   end
endmodule

// ===== rtl/srw_pclk.sv
// Pixel clock divider with output polarity select
`timescale 1ns/1ps
module srw_pclk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic invert,
   output logic pix_tick,
   output logic pclk
);
   logic next_tick;
   logic next_pclk;

   // Tick marks the launch edge; polarity flips the clock at the next master clock, through the pclk register
   always_comb begin
      next_tick = ~pix_tick;
      next_pclk = pix_tick ^ invert;
   end

   // Divider registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_tick <= 1'b0;
         pclk <= 1'b0;
      end else begin
         pix_tick <= next_tick;
         pclk <= next_pclk;
      end
   end
endmodule

// ===== tb/srw_rx_model.sv
// Pixel receiver model that measures frame and line timing
`timescale 1ns/1ps
module srw_rx_model (
   input wire logic clk,
   input wire logic fs,
   input wire logic fv,
   input wire logic lv,
   input wire logic pclk,
   input wire logic [10:0] row,
   input wire logic [10:0] col,
   output int lines,
   output int period,
   output int fs_fv,
   output int lv_len,
   output int gap,
   output logic [10:0] row0,
   output logic [10:0] col0,
   output logic pclk_lv
);
   int cyc = 0;
   int n = 0;
   int run = 0;
   int low = 0;
   logic fv_q = 1'b0;
   logic lv_q = 1'b0;
   // Line count and period of one frame are published at the next frame start
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (fs === 1'b1) begin
         period = cyc;
         lines = n;
         cyc = 0;
         n = 0;
      end
      if (fv && !fv_q) fs_fv = cyc;
      // Line start: window origin, blank gap and clock phase
      if (lv && !lv_q) begin
         if (n == 0) begin
            row0 = row;
            col0 = col;
         end
         n = n + 1;
         gap = low;
         pclk_lv = pclk;
      end
      if (!lv && lv_q) lv_len = run;
      run = lv ? run + 1 : 0;
      low = (fv && !lv) ? low + 1 : 0;
      fv_q = fv;
      lv_q = lv;
   end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the readout window timing block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
   end \
end
module testbench;
   import srw_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [1:0] context_select = 2'b00;
   logic sync_changes = 1'b0;
   logic show_bad_frames = 1'b0;
   logic pixel_out_clock, frame_valid, line_valid, frame_start, bad_frame;
   logic [10:0] row_addr, col_addr, row0, col0;
   logic pclk_lv, pol;
   int lines, period, fs_fv, lv_len, gap;
   int failures = 0;
   int n_tests = 0;
   logic [15:0] rst_tab [0:10];
   initial rst_tab = '{FIXED_CODE, RST_ROW, RST_COL, RST_NROWS, RST_NCOLS, RST_HB_B,
      RST_VB_B, RST_HB_A, RST_VB_A, RST_INTEG, RST_PCLK};
   always #10 ref_clk = ~ref_clk;
   srw_core u_srw_core (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .context_select(context_select), .sync_changes(sync_changes),
      .show_bad_frames(show_bad_frames), .pixel_out_clock(pixel_out_clock),
      .frame_valid(frame_valid), .line_valid(line_valid), .row_addr(row_addr),
      .col_addr(col_addr), .frame_start(frame_start), .bad_frame(bad_frame));
   srw_rx_model u_srw_rx_model (.clk(ref_clk), .fs(frame_start), .fv(frame_valid),
      .lv(line_valid), .pclk(pixel_out_clock), .row(row_addr), .col(col_addr),
      .lines(lines), .period(period), .fs_fv(fs_fv), .lv_len(lv_len), .gap(gap),
      .row0(row0), .col0(col0), .pclk_lv(pclk_lv));
   // Register write: one strobe cycle, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask
   // Register read compared with an expected word
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      @(posedge ref_clk);
      #1 `CHK($sformatf("reg %0h", a), e, reg_rdata)
   endtask
   // Wait for frame starts, letting the model publish its stats
   task automatic wait_fs(input int k);
      repeat (k) @(posedge frame_start);
      @(posedge ref_clk);
      #1;
   endtask
   task automatic done(input string s);
      $display("test %s finished, mismatches so far %0d", s, failures);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog: start-up blanking near 88700 clocks plus short frames near 11100
   initial begin
      repeat (105000) @(posedge ref_clk);
      failures++;
      give_verdict();
   end
   // Main sequence; the first window setup lands before the first frame start
   initial begin
      repeat (6) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      for (int i = 0; i < NREG; i++) rd(i[7:0], rst_tab[i]);
      wr(OFS_FIXED, 16'h1234);
      rd(OFS_FIXED, FIXED_CODE);
      rd(8'h0b, 16'h0000);
      wr(OFS_ROW, 16'hffff);
      rd(OFS_ROW, MASK_11);
      wr(OFS_HB_B, 16'hffff);
      rd(OFS_HB_B, MASK_14);
      wr(OFS_VB_B, 16'hffff);
      rd(OFS_VB_B, MASK_15);
      wr(OFS_INTEG, 16'hffff);
      rd(OFS_INTEG, MASK_16);
      done("registers");
      // Small window, first row and column kept clear of the dark area
      wr(OFS_ROW, 16'h0020);
      wr(OFS_COL, 16'h0040);
      wr(OFS_NROWS, 16'h0002);
      wr(OFS_NCOLS, 16'h0009);
      wr(OFS_HB_A, 16'h0004);
      wr(OFS_HB_B, 16'h0006);
      wr(OFS_VB_A, 16'h000c);
      wr(OFS_VB_B, 16'h000e);
      wr(OFS_INTEG, 16'h000a);
      wait_fs(2);
      `CHK("lines", 0, lines)
      wait_fs(1);
      `CHK("first row", 11'h020, row0)
      `CHK("first col", 11'h040, col0)
      `CHK("lines", 2, lines)
      `CHK("line len", 18, lv_len)
      `CHK("hblank", 8, gap)
      `CHK("lead", 208, fs_fv)
      `CHK("period", 572, period)
      pol = pclk_lv;
      done("context A");
      // Polarity written early in a frame must show in that same frame
      wr(OFS_PCLK, 16'h0111);
      wait_fs(1);
      `CHK("edge", ~pol, pclk_lv)
      rd(OFS_PCLK, 16'h0111);
      done("polarity");
      // Switch context in vertical blanking so no shown row changes length
      @(negedge frame_valid);
      #1 context_select = 2'b11;
      wait_fs(3);
      `CHK("hblank", 12, gap)
      `CHK("period", 720, period)
      wr(OFS_INTEG, 16'h001e);
      wait_fs(3);
      `CHK("period", 930, period)
      done("context B");
      // Held change, then release with bad frames shown
      sync_changes = 1'b1;
      wr(OFS_NROWS, 16'h0003);
      wait_fs(3);
      `CHK("lines", 2, lines)
      show_bad_frames = 1'b1;
      sync_changes = 1'b0;
      wait_fs(1);
      `CHK("bad", 1'b1, bad_frame)
      wait_fs(1);
      `CHK("lines", 3, lines)
      done("sync and show");
      give_verdict();
   end
endmodule
